/* rtl/acb_pkg.sv */
// Constants, register map and types for the accelerometer register front end.
// Assumes a 20 MHz ref_clk and a serial register bus master outside the device.
// Overview of operation
// - Main control 0x40: standby, high resolution, 8g range.
// - Main control 0xC0: operating bit set, sampling starts, high resolution, 8g.
// - Rate select at 0x1B; code 0x02 is 50 Hz and the reset value.
// - When operating, each axis shows as low/high two's complement bytes.
// - Main control 0x60: standby, high resolution, 8g, new-sample interrupt on.
// - Pin config 0x38: pin enabled, active high, pulse of 0.03 to 0.05 ms.
// - Routing 0x10 sends the new-sample event to the first interrupt pin.
// - Main control 0xE0: operating, high resolution, 8g, new-sample interrupt on.
// - New-sample interrupt sets status bit 4 and second source bit 4.
// - Main control 0x00: standby, low power, 8g range.
// - Routing 0x40 sends the buffer-full event to the first interrupt pin.
// - Buffer control two 0xA0: buffer on, 8-bit, full reporting, FIFO mode.
// - Main control 0x80: operating in low power with 8g range.
// - Buffer read port returns two's complement bytes, oldest first.
// - Buffer-full interrupt sets status bit 4 and second source bit 6.
// - 8-bit buffering stores X high, Y high, Z high per sample.
// - FIFO counts as full and flags it at 2043 bytes, 681 samples.
// - No address auto-increment while reading the buffer read port.
package acb_pkg;
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned RATE_HZ_DEF    = 50;
    localparam int unsigned RATE_50HZ_CYCLES = CLK_HZ / RATE_HZ_DEF;
    localparam logic [3:0]  RATE_CODE_BASE = 4'h2;
    localparam logic [3:0]  RATE_CODE_MAX  = 4'h7;
    localparam int unsigned PULSE_MIN_NS   = 30_000;
    localparam int unsigned PULSE_MAX_NS   = 50_000;
    localparam int unsigned PULSE_MIN_CYC  = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PULSE_MAX_CYC  = PULSE_MAX_NS / CLK_PERIOD_NS;
    localparam logic [9:0]  PULSE_CYC      = 10'((PULSE_MIN_CYC + PULSE_MAX_CYC) / 2);
    localparam int unsigned BUF_BYTES      = 2048;
    localparam int unsigned BUF_FULL_BYTES = 2043;
    localparam int unsigned AXES           = 3;
    // Arbitrary bus address, not tied to any product
    localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h2A;
    // Register offsets
    localparam logic [7:0] ADDR_X_LOW      = 8'h06;
    localparam logic [7:0] ADDR_Z_HIGH     = 8'h0B;
    localparam logic [7:0] ADDR_STATUS     = 8'h15;
    localparam logic [7:0] ADDR_SECOND_SRC = 8'h17;
    localparam logic [7:0] ADDR_MAIN_CTL   = 8'h18;
    localparam logic [7:0] ADDR_RATE_SEL   = 8'h1B;
    localparam logic [7:0] ADDR_PIN_CFG    = 8'h1C;
    localparam logic [7:0] ADDR_ROUTING    = 8'h1F;
    localparam logic [7:0] ADDR_BUF_CTL2   = 8'h3B;
    localparam logic [7:0] ADDR_BUF_READ   = 8'h3F;
    // Reset values
    localparam logic [7:0] MAIN_CTL_RST = 8'h00;
    localparam logic [7:0] RATE_SEL_RST = 8'h02;
    localparam logic [7:0] PIN_CFG_RST  = 8'h10;
    localparam logic [7:0] ROUTING_RST  = 8'h00;
    localparam logic [7:0] BUF_CTL2_RST = 8'h00;
    // Field positions
    localparam int CTL_OPERATING_BIT = 7;
    localparam int CTL_HIRES_BIT     = 6;
    localparam int CTL_NEWSAMPLE_BIT = 5;
    localparam int PIN_EN_BIT        = 5;
    localparam int PIN_POL_BIT       = 4;
    localparam int PIN_PULSE_BIT     = 3;
    localparam int ROUTE_NEWSAMPLE_BIT = 4;
    localparam int ROUTE_FULL_BIT    = 6;
    localparam int BUF_EN_BIT        = 7;
    localparam int BUF_RES_BIT       = 6;
    localparam int BUF_FULLIE_BIT    = 5;
    localparam logic [1:0] BUF_MODE_FIFO = 2'h0;
    localparam int SRC_NEWSAMPLE_BIT = 4;
    localparam int SRC_FULL_BIT      = 6;
    localparam int STATUS_INT_BIT    = 4;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [3:0] BIT_PRE   = 4'hF;

    typedef enum logic [2:0] {ST_IDLE, ST_DEVADDR, ST_REGADDR, ST_WRITE, ST_READ} acb_bus_state_t;
endpackage

/* rtl/acb_core.sv */
// Accelerometer register front end: serial register slave, sampling, FIFO, interrupt pin.
// Assumes axis words come from converter logic on ref_clk; bus pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module acb_core
    import acb_pkg::*;
#(
    parameter int unsigned RATE_BASE_CYCLES = RATE_50HZ_CYCLES,
    parameter int unsigned BUF_DEPTH        = BUF_BYTES,
    parameter int unsigned FULL_LEVEL       = BUF_FULL_BYTES,
    parameter logic [6:0]  DEV_ADDR         = DEV_ADDR_DEFAULT
)(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    input  wire logic [15:0] axisX,
    input  wire logic [15:0] axisY,
    input  wire logic [15:0] axisZ,
    output logic             firstIrqPin
);
    localparam int PW = $clog2(BUF_DEPTH);
    localparam logic [PW:0] FULL_CNT  = (PW+1)'(FULL_LEVEL);
    localparam logic [PW:0] ROOM_CNT  = (PW+1)'(FULL_LEVEL - AXES);
    localparam logic [PW:0] ONE_CNT   = (PW+1)'(1);

    logic [1:0]     sclSync_q;
    logic [1:0]     sdaSync_q;
    logic           sclPrev_q;
    logic           sdaPrev_q;
    acb_bus_state_t state_q;
    logic [3:0]     bitCnt_q;
    logic [7:0]     rxShift_q;
    logic [7:0]     txShift_q;
    logic [7:0]     regPtr_q;
    logic           readMode_q;
    logic           masterAck_q;
    logic           sdaOe_q;
    logic [7:0]     mainCtl_q;
    logic [7:0]     rateSel_q;
    logic [7:0]     pinCfg_q;
    logic [7:0]     routing_q;
    logic [7:0]     bufCtl2_q;
    logic [31:0]    rateCnt_q;
    logic [31:0]    ratePeriod;
    logic           sampleTick_q;
    logic [15:0]    axis_q [AXES];
    logic [1:0]     pushPhase_q;
    logic [7:0]     bufMem [BUF_DEPTH];
    logic [PW-1:0]  wrPtr_q;
    logic [PW-1:0]  rdPtr_q;
    logic [PW:0]    bufCount_q;
    logic           newSampleFlag_q;
    logic           bufferFullFlag_q;
    logic [9:0]     pulseCnt_q;
    logic           firstIrqPin_q;
    logic [7:0]     rdByte;

    // Bus pin synchronisers; edges seen only from the second stage on
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            sclSync_q <= {sclSync_q[0], sclIn};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end

    wire logic sclRise  = sclSync_q[1] & ~sclPrev_q;
    wire logic sclFall  = ~sclSync_q[1] & sclPrev_q;
    wire logic busStart = sclSync_q[1] & sclPrev_q & sdaPrev_q & ~sdaSync_q[1];
    wire logic busStop  = sclSync_q[1] & sclPrev_q & ~sdaPrev_q & sdaSync_q[1];
    wire logic byteDone = sclFall && bitCnt_q == BIT_LAST;
    wire logic ackDone  = sclFall && bitCnt_q == BIT_ACK;
    wire logic wrStrobe = byteDone && state_q == ST_WRITE;
    wire logic rdStrobe = ackDone && ((state_q == ST_DEVADDR && readMode_q)
                                      || (state_q == ST_READ && masterAck_q));
    wire logic operating = mainCtl_q[CTL_OPERATING_BIT];
    wire logic bufOn = bufCtl2_q[BUF_EN_BIT] && !bufCtl2_q[BUF_RES_BIT]
                       && bufCtl2_q[1:0] == BUF_MODE_FIFO;
    wire logic popReq = rdStrobe && regPtr_q == ADDR_BUF_READ && bufCount_q != '0;
    wire logic pushReq = pushPhase_q != 2'h0;
    wire logic fullHit = bufOn && pushReq && !popReq && bufCount_q == FULL_CNT - ONE_CNT;
    wire logic newSampleSet = sampleTick_q && mainCtl_q[CTL_NEWSAMPLE_BIT];
    wire logic fullSet = fullHit && bufCtl2_q[BUF_FULLIE_BIT];
    wire logic srcClear = rdStrobe && regPtr_q == ADDR_SECOND_SRC;
    wire logic [7:0] axisIdx = regPtr_q - ADDR_X_LOW;

    // Byte-level slave sequencer
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q     <= ST_IDLE;
            bitCnt_q    <= BIT_PRE;
            rxShift_q   <= 8'h00;
            txShift_q   <= 8'h00;
            readMode_q  <= 1'b0;
            masterAck_q <= 1'b0;
            sdaOe_q     <= 1'b0;
        end
        else if (busStart)
        begin
            state_q  <= ST_DEVADDR;
            bitCnt_q <= BIT_PRE;
            sdaOe_q  <= 1'b0;
        end
        else if (busStop)
        begin
            state_q <= ST_IDLE;
            sdaOe_q <= 1'b0;
        end
        else if (state_q != ST_IDLE)
        begin
            if (sclRise && bitCnt_q <= BIT_LAST && state_q != ST_READ)
                rxShift_q <= {rxShift_q[6:0], sdaSync_q[1]};
            if (sclRise && bitCnt_q == BIT_ACK && state_q == ST_READ)
                masterAck_q <= ~sdaSync_q[1];
            if (byteDone)
            begin
                bitCnt_q <= BIT_ACK;
                sdaOe_q  <= 1'b1;
                case (state_q)
                    ST_DEVADDR:
                    begin
                        readMode_q <= rxShift_q[0];
                        if (rxShift_q[7:1] != DEV_ADDR)
                        begin
                            state_q <= ST_IDLE;
                            sdaOe_q <= 1'b0;
                        end
                    end
                    ST_READ: sdaOe_q <= 1'b0;
                    default: sdaOe_q <= 1'b1;
                endcase
            end
            else if (ackDone)
            begin
                bitCnt_q <= 4'h0;
                sdaOe_q  <= 1'b0;
                case (state_q)
                    ST_DEVADDR: state_q <= readMode_q ? ST_READ : ST_REGADDR;
                    ST_REGADDR: state_q <= ST_WRITE;
                    ST_READ:
                        if (!masterAck_q)
                            state_q <= ST_IDLE;
                    default: state_q <= state_q;
                endcase
                if (rdStrobe)
                begin
                    txShift_q <= rdByte;
                    sdaOe_q   <= ~rdByte[7];
                end
            end
            else if (sclFall)
            begin
                bitCnt_q <= bitCnt_q + 4'h1;
                if (state_q == ST_READ)
                begin
                    txShift_q <= {txShift_q[6:0], 1'b0};
                    sdaOe_q   <= ~txShift_q[6];
                end
            end
        end
    end

    // Register pointer
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            regPtr_q <= 8'h00;
        else if (byteDone && state_q == ST_REGADDR)
            regPtr_q <= rxShift_q;
        else if ((wrStrobe || rdStrobe) && regPtr_q != ADDR_BUF_READ)
            regPtr_q <= regPtr_q + 8'h01;
    end

    // Read data mux
    always_comb
    begin
        rdByte = 8'h00;
        case (regPtr_q)
            ADDR_MAIN_CTL:   rdByte = mainCtl_q;
            ADDR_RATE_SEL:   rdByte = rateSel_q;
            ADDR_PIN_CFG:    rdByte = pinCfg_q;
            ADDR_ROUTING:    rdByte = routing_q;
            ADDR_BUF_CTL2:   rdByte = bufCtl2_q;
            ADDR_BUF_READ:
                if (bufCount_q != '0)
                    rdByte = bufMem[rdPtr_q];
            ADDR_STATUS:     rdByte[STATUS_INT_BIT] = newSampleFlag_q | bufferFullFlag_q;
            ADDR_SECOND_SRC:
            begin
                rdByte[SRC_NEWSAMPLE_BIT] = newSampleFlag_q;
                rdByte[SRC_FULL_BIT]      = bufferFullFlag_q;
            end
            default:
                if (regPtr_q >= ADDR_X_LOW && regPtr_q <= ADDR_Z_HIGH)
                    rdByte = axisIdx[0] ? axis_q[axisIdx[2:1]][15:8] : axis_q[axisIdx[2:1]][7:0];
        endcase
    end

    // Configuration registers; host keeps them stable while operating
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            mainCtl_q <= MAIN_CTL_RST;
            rateSel_q <= RATE_SEL_RST;
            pinCfg_q  <= PIN_CFG_RST;
            routing_q <= ROUTING_RST;
            bufCtl2_q <= BUF_CTL2_RST;
        end
        else if (wrStrobe)
        begin
            case (regPtr_q)
                ADDR_MAIN_CTL: mainCtl_q <= rxShift_q;
                ADDR_RATE_SEL: rateSel_q <= rxShift_q;
                ADDR_PIN_CFG:  pinCfg_q  <= rxShift_q;
                ADDR_ROUTING:  routing_q <= rxShift_q;
                ADDR_BUF_CTL2: bufCtl2_q <= rxShift_q;
                default:       mainCtl_q <= mainCtl_q;
            endcase
        end
    end

    // Rate divider: each code step up to 7 doubles or halves the 50 Hz period; codes above 7 keep the code 7 period
    always_comb
    begin
        if (rateSel_q[3:0] >= RATE_CODE_MAX)
            ratePeriod = RATE_BASE_CYCLES >> (RATE_CODE_MAX - RATE_CODE_BASE);
        else if (rateSel_q[3:0] >= RATE_CODE_BASE)
            ratePeriod = RATE_BASE_CYCLES >> (rateSel_q[3:0] - RATE_CODE_BASE);
        else
            ratePeriod = RATE_BASE_CYCLES << (RATE_CODE_BASE - rateSel_q[3:0]);
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !operating)
        begin
            rateCnt_q    <= 32'h0;
            sampleTick_q <= 1'b0;
        end
        else if (rateCnt_q >= ratePeriod - 32'h1)
        begin
            rateCnt_q    <= 32'h0;
            sampleTick_q <= 1'b1;
        end
        else
        begin
            rateCnt_q    <= rateCnt_q + 32'h1;
            sampleTick_q <= 1'b0;
        end
    end

    // Output registers and the three-byte push sequence
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < AXES; i++)
                axis_q[i] <= 16'h0000;
            pushPhase_q <= 2'h0;
        end
        else if (sampleTick_q)
        begin
            axis_q[0] <= axisX;
            axis_q[1] <= axisY;
            axis_q[2] <= axisZ;
            // Whole samples only, so the byte stream never loses its X,Y,Z phase
            pushPhase_q <= (bufOn && bufCount_q <= ROOM_CNT) ? 2'h1 : 2'h0;
        end
        else if (pushReq)
            pushPhase_q <= (pushPhase_q == 2'(AXES)) ? 2'h0 : pushPhase_q + 2'h1;
    end

    // Sample buffer
    always_ff @(posedge ref_clk)
    begin
        if (pushReq && bufOn)
            bufMem[wrPtr_q] <= axis_q[pushPhase_q - 2'h1][15:8];
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !bufOn)
        begin
            wrPtr_q    <= '0;
            rdPtr_q    <= '0;
            bufCount_q <= '0;
        end
        else
        begin
            if (pushReq)
                wrPtr_q <= (wrPtr_q == PW'(BUF_DEPTH - 1)) ? '0 : wrPtr_q + PW'(1);
            if (popReq)
                rdPtr_q <= (rdPtr_q == PW'(BUF_DEPTH - 1)) ? '0 : rdPtr_q + PW'(1);
            if (pushReq && !popReq)
                bufCount_q <= bufCount_q + ONE_CNT;
            else if (popReq && !pushReq)
                bufCount_q <= bufCount_q - ONE_CNT;
        end
    end

    // Interrupt source flags; reading the second source register clears them, a new event wins
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            newSampleFlag_q  <= 1'b0;
            bufferFullFlag_q <= 1'b0;
        end
        else
        begin
            if (newSampleSet)
                newSampleFlag_q <= 1'b1;
            else if (srcClear)
                newSampleFlag_q <= 1'b0;
            if (fullSet)
                bufferFullFlag_q <= 1'b1;
            else if (srcClear)
                bufferFullFlag_q <= 1'b0;
        end
    end

    // Interrupt pin: timed pulse or level following the routed flags
    wire logic pinEvent = (newSampleSet && routing_q[ROUTE_NEWSAMPLE_BIT])
                          || (fullSet && routing_q[ROUTE_FULL_BIT]);
    wire logic pinLevel = (newSampleFlag_q && routing_q[ROUTE_NEWSAMPLE_BIT])
                          || (bufferFullFlag_q && routing_q[ROUTE_FULL_BIT]);
    wire logic pinActive = pinCfg_q[PIN_PULSE_BIT] ? (pulseCnt_q != 10'h0) : pinLevel;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            pulseCnt_q <= 10'h0;
        else if (pinEvent)
            pulseCnt_q <= PULSE_CYC;
        else if (pulseCnt_q != 10'h0)
            pulseCnt_q <= pulseCnt_q - 10'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            firstIrqPin_q <= 1'b0;
        else
            firstIrqPin_q <= pinCfg_q[PIN_EN_BIT] && (pinActive == pinCfg_q[PIN_POL_BIT]);
    end

    assign sdaOut      = 1'b0;
    assign sdaOe       = sdaOe_q;
    assign firstIrqPin = firstIrqPin_q;
endmodule
`default_nettype wire

/* testbench/acb_core_properties.sv */
// Port-level checks on the accelerometer front end, bound into acb_core.
// Assumes the pin runs in pulse mode and SCL phases last at least 4 clocks.
`timescale 1ns/10ps
`default_nettype none
module acb_core_checker
    import acb_pkg::*;
#(
    parameter int unsigned RATE_BASE_CYCLES = RATE_50HZ_CYCLES,
    parameter int unsigned BUF_DEPTH        = BUF_BYTES,
    parameter int unsigned FULL_LEVEL       = BUF_FULL_BYTES,
    parameter logic [6:0]  DEV_ADDR         = DEV_ADDR_DEFAULT
)(
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        sclIn,
    input wire logic        sdaIn,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    input wire logic [15:0] axisX,
    input wire logic [15:0] axisY,
    input wire logic [15:0] axisZ,
    input wire logic        firstIrqPin
);
    logic [9:0] hiCnt_q;
    // Cycles the pin has stood high so far
    always_ff @(posedge ref_clk)
        hiCnt_q <= (sys_rst || !firstIrqPin) ? 10'h000 : hiCnt_q + 10'h001;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_pulse_len; $fell(firstIrqPin) |-> hiCnt_q == PULSE_CYC; endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pin pulse length wrong");
    property p_pulse_cap; hiCnt_q <= 10'(PULSE_MAX_CYC); endproperty
    a_pulse_cap: assert property (p_pulse_cap) else $error("pin pulse too long");
    property p_pulse_hold; $rose(firstIrqPin) |=> firstIrqPin[*8]; endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("pin pulse collapsed early");
    property p_reset_quiet; $fell(sys_rst) |-> !sdaOe && !firstIrqPin; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    property p_open_drain; sdaOut == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
    // Data may only move while SCL is low, else it reads as START or STOP
    property p_oe_scl_low; $changed(sdaOe) |-> !sclIn; endproperty
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with SCL high");
    property p_stop_idle; ($rose(sdaIn) && sclIn) |-> !sdaOe[*8]; endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("data driven after STOP");
    property p_start_quiet; (sclIn && $fell(sdaIn)) |=> !sdaOe[*4]; endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("data driven right after START");
endmodule
bind acb_core acb_core_checker #(.RATE_BASE_CYCLES(RATE_BASE_CYCLES), .BUF_DEPTH(BUF_DEPTH),
    .FULL_LEVEL(FULL_LEVEL), .DEV_ADDR(DEV_ADDR)) acb_core_checker_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .axisX(axisX), .axisY(axisY), .axisZ(axisZ), .firstIrqPin(firstIrqPin));
`default_nettype wire

/* testbench/acb_host_model.sv */
// Host controller model: serial register bus master with 400 ns SCL.
// Assumes a pull-up on SDA; every pin change lands 1 ns after a ref_clk edge.
`timescale 1ns/10ps
`default_nettype none
module acb_host_model
    import acb_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sdaOe,
    input  wire logic sdaOut,
    output logic      sclIn,
    output logic      sdaIn,
    output logic [7:0] nackCnt
);
    logic hostLow = 1'b0;
    // Wired-AND with the pull-up: a released line reads high
    assign sdaIn = hostLow ? 1'b0 : (sdaOe ? sdaOut : 1'b1);
    initial
    begin
        sclIn = 1'b1;
        nackCnt = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Read sample taken late in the high phase, clear of the device's sync delay
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        hostLow = ~b;
        tick(2);
        sclIn = 1'b1;
        tick(3);
        r = sdaIn;
        tick(1);
        sclIn = 1'b0;
    endtask
    // a=1 gives START or repeated START, a=0 gives STOP
    task automatic cond(input logic a);
        hostLow = ~a;
        tick(5);
        sclIn = 1'b1;
        tick(4);
        hostLow = a;
        tick(4);
        sclIn = ~a;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic [7:0] r);
        logic x;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(b[i], x);
            r[i] = x;
        end
    endtask
    task automatic send(input logic [7:0] b);
        logic [7:0] r;
        logic       a;
        put_byte(b, r);
        bit_io(1'b1, a);
        if (a !== 1'b0)
            nackCnt = nackCnt + 8'h01;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        cond(1'b1);
        send({DEV_ADDR_DEFAULT, 1'b0});
        send(a);
        send(d);
        cond(1'b0);
    endtask
    // Repeated START keeps the pointer; the last byte is refused
    task automatic read_regs(input logic [7:0] a, input int n, output logic [7:0] q[$]);
        logic [7:0] r;
        logic       x;
        q = {};
        cond(1'b1);
        send({DEV_ADDR_DEFAULT, 1'b0});
        send(a);
        cond(1'b1);
        send({DEV_ADDR_DEFAULT, 1'b1});
        for (int i = 0; i < n; i++)
        begin
            put_byte(8'hFF, r);
            q.push_back(r);
            bit_io(i == n - 1, x);
        end
        cond(1'b0);
    endtask
endmodule
`default_nettype wire

/* testbench/accel_config_irq_sample_buffer_tb.sv */
// Self-checking bench: registers, axis readout, sample interrupt, buffer fill and drain.
// Assumes the host model for all bus traffic and shortened rate and buffer counts.
`timescale 1ns/10ps
`default_nettype none
module accel_config_irq_sample_buffer_tb
    import acb_pkg::*;
;
    localparam int unsigned RATE = 2000;
    localparam int unsigned FULL = 12;
    localparam logic [7:0] RD_A [6] = '{8'h18, 8'h1B, 8'h1C, 8'h1F, 8'h3B, 8'h30};
    localparam logic [7:0] RD_V [6] = '{MAIN_CTL_RST, 8'h02, PIN_CFG_RST, ROUTING_RST, BUF_CTL2_RST, 8'h00};
    localparam logic [7:0] WR_A [9] = '{8'h18, 8'h18, 8'h18, 8'h1C, 8'h1F, 8'h1F, 8'h3B, 8'h3B, 8'h3F};
    localparam logic [7:0] WR_D [9] = '{8'h40, 8'h60, 8'h00, 8'h38, 8'h40, 8'h10, 8'hA0, 8'h00, 8'h5A};
    logic        refClk;
    logic        sysRst;
    logic        sclIn;
    logic        sdaIn;
    logic        sdaOut;
    logic        sdaOe;
    logic        firstIrqPin;
    logic [7:0]  nackCnt;
    logic [15:0] ax [3];
    logic [7:0]  q [$];
    int          fails = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          n;
    acb_core #(.RATE_BASE_CYCLES(RATE), .BUF_DEPTH(16), .FULL_LEVEL(FULL), .DEV_ADDR(DEV_ADDR_DEFAULT)) acb_core_i (
        .ref_clk(refClk), .sys_rst(sysRst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .axisX(ax[0]), .axisY(ax[1]), .axisZ(ax[2]), .firstIrqPin(firstIrqPin));
    acb_host_model acb_host_model_i (.ref_clk(refClk), .sdaOe(sdaOe), .sdaOut(sdaOut), .sclIn(sclIn),
        .sdaIn(sdaIn), .nackCnt(nackCnt));
    initial
    begin
        refClk = 1'b0;
        forever #25 refClk = ~refClk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Whole run needs about 30000 cycles
    always @(posedge refClk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            print_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge refClk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acb_host_model_i.write_reg(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input int c);
        acb_host_model_i.read_regs(a, c, q);
    endtask
    task automatic wait_pin(input int lim);
        for (int i = 0; i < lim && firstIrqPin !== 1'b1; i++)
            tick(1);
    endtask
    initial
    begin
        sysRst = 1'b1;
        ax = '{16'h1234, 16'hFEDC, 16'h8001};
        tick(16);
        sysRst = 1'b0;
        tick(4);
        for (int i = 0; i < 6; i++)
        begin
            rd(RD_A[i], 1);
            check(16'(q[0]), 16'(RD_V[i]));
        end
        // Last entry is the read-only port: write dropped, empty read gives zero
        for (int i = 0; i < 9; i++)
        begin
            wr(WR_A[i], WR_D[i]);
            rd(WR_A[i], 1);
            check(16'(q[0]), (i == 8) ? 16'h0000 : 16'(WR_D[i]));
        end
        wr(8'h18, 8'h40);
        wr(8'h1B, 8'h02);
        wr(8'h18, 8'hC0);
        tick(2 * RATE + 50);
        rd(ADDR_X_LOW, 6);
        for (int i = 0; i < 6; i++)
            check(16'(q[i]), 16'(i[0] ? ax[i / 2][15:8] : ax[i / 2][7:0]));
        wr(8'h18, 8'h40);
        ax[0] = 16'h0BAD;
        tick(2 * RATE);
        rd(ADDR_X_LOW, 1);
        check(16'(q[0]), 16'h0034);
        wr(8'h18, 8'h60);
        wr(8'h1C, 8'h38);
        wr(8'h1F, 8'h10);
        wr(8'h18, 8'hE0);
        wait_pin(3 * RATE);
        for (n = 0; n < 2000 && firstIrqPin === 1'b1; n++)
            tick(1);
        check(16'(n), 16'(PULSE_CYC));
        rd(ADDR_STATUS, 1);
        check(16'(q[0] & 8'h10), 16'h0010);
        rd(ADDR_SECOND_SRC, 1);
        check(16'(q[0] & 8'h10), 16'h0010);
        wr(8'h18, 8'h00);
        tick(PULSE_CYC);
        wr(8'h1F, 8'h40);
        wr(8'h3B, 8'hA0);
        // Code 3 halves the period; a wrong decode at the base rate overruns the limit
        wr(8'h1B, 8'h03);
        wr(8'h18, 8'h80);
        wait_pin((FULL / 3 + 2) * RATE / 2);
        check(16'(firstIrqPin), 16'h0001);
        wr(8'h18, 8'h00);
        rd(ADDR_STATUS, 1);
        check(16'(q[0] & 8'h10), 16'h0010);
        rd(ADDR_SECOND_SRC, 1);
        check(16'(q[0] & 8'h40), 16'h0040);
        rd(ADDR_BUF_READ, FULL + 1);
        for (int i = 0; i < FULL; i++)
            check(16'(q[i]), 16'(ax[i % 3][15:8]));
        check(16'(q[FULL]), 16'h0000);
        check(16'(nackCnt), 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
